// *** rtl/rcs_ctrl_status.sv ***
// Behaviour
// R1 - Unimplemented bits ignore writes, read zero
// R2 - Halt flag set clears adjust and controls
// R3 - Host writes zero to adjust register MSB
// R4 - Control one layout at Eh, resets zero
// R5 - Alarm enable bits gate alarm interrupts
// R6 - Hour mode: zero twelve-hour, one 24-hour
// R7 - Twelve-hour PM codes carry bit five
// R8 - Host sets hour mode before time data
// R9 - Clock out runs unless both disables set
// R10 - Scratch bits plain storage, cleared on halt
// R11 - Host keeps test bit at zero
// R12 - Periodic select decodes off, low, pulse, level
// R13 - Level events at second, minute, hour, month boundaries
// R14 - Pulse mode: second increments 92 us later
// R15 - Second write resets divider, output low
// R16 - Level mode: falling edge with second increment
// R17 - Adjustment shifts periodic timing by counts
// R18 - Control two layout at Fh, resets 10h
// R19 - Threshold select picks monitor threshold
// R20 - Low-voltage flag sticky, zero write clears
// R21 - Halt flag sets on stop, stays set
// R22 - Halt stops interrupt, starts clock out
// R23 - Zero write clears halt flag
// R24 - Halt sensing only while chip enable low
// R25 - Level mode periodic flag clears on zero
// R26 - Alarm flags set on match, zero clears
// R27 - Supply sampled once per second
`timescale 1ns/1ps

module rcs_ctrl_status
    import rcs_pkg::*;
#(
    parameter int unsigned TICK_DELAY = TICK_DELAY_CYC
) (
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             arst_n,
    // Register port from the serial decoder
    input  wire logic [3:0]       reg_addr,
    input  wire logic [7:0]       reg_wdata,
    input  wire logic             reg_wr,
    input  wire logic             sec_write,
    output logic      [7:0]       reg_rdata,
    // Pins and analog sense, asynchronous
    input  wire logic             xtal_clk,
    input  wire logic             chip_enable,
    input  wire logic             osc_halt,
    input  wire logic             vdd_low,
    // Time counter status, same clock
    input  wire logic             sec_at_last,
    input  wire logic             min_at_last,
    input  wire logic             hour_at_last,
    input  wire logic             day_at_last,
    input  wire logic [4:0]       hour_bin,
    input  wire logic             weekly_match,
    input  wire logic             daily_match,
    // Oscillation adjustment step
    input  wire logic             adj_event,
    input  wire logic             adj_shorten,
    input  wire logic [ADJ_W-1:0] adj_counts,
    // Outputs
    output logic                  interrupt_out_n,
    output logic                  crystal_clock_out,
    output logic                  sec_tick,
    output logic                  adj_clear,
    output logic                  hour_24_mode,
    output logic                  test_mode,
    output logic                  threshold_select,
    output logic      [5:0]       hour_code
);

    // ------------------------------------------------------------
    // Synchronisers and crystal edge detect
    // ------------------------------------------------------------
    logic [3:0] pins_s;
    logic       xtal_s;
    logic       ce_s;
    logic       halt_s;
    logic       vlow_s;
    logic       xtal_d;
    logic       xtal_rise;

    rcs_sync #(.WIDTH(4)) u_sync (
        .ref_clk  (ref_clk),
        .arst_n   (arst_n),
        .async_in ({xtal_clk, chip_enable, osc_halt, vdd_low}),
        .sync_out (pins_s)
    );

    assign xtal_s    = pins_s[3];
    assign ce_s      = pins_s[2];
    assign halt_s    = pins_s[1];
    assign vlow_s    = pins_s[0];
    assign xtal_rise = xtal_s & ~xtal_d;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0]    cr1;
    logic [7:0]    cr2;
    logic [7:0]    next_cr1;
    logic [7:0]    next_cr2;
    logic          next_adj_clear;
    logic          wr_cr1;
    logic          wr_cr2;
    logic          halt_set;
    logic          halt_rise;
    logic          level_mode;
    logic          level_evt;
    logic          per_low;
    logic          sec_evt;
    rcs_periodic_t per_sel;

    assign per_sel    = rcs_periodic_t'(cr1[B_PERIODIC_SELECT_HI:
                                            B_PERIODIC_SELECT_LO]);
    assign level_mode = cr1[B_PERIODIC_SELECT_HI];
    assign wr_cr1     = reg_wr && reg_addr == ADDR_ALARM_TIMER_CONTROL;
    assign wr_cr2     = reg_wr && reg_addr == ADDR_STATUS_FLAGS_CONTROL;
    assign halt_set   = halt_s && !ce_s; // [R24] [R21]
    assign halt_rise  = halt_set && !cr2[B_OSC_HALT_FLAG];

    always_comb
    begin
        unique case (per_sel) // [R13]
            PER_LVL_SEC:   level_evt = sec_evt;
            PER_LVL_MIN:   level_evt = sec_evt && sec_at_last;
            PER_LVL_HOUR:  level_evt = sec_evt && sec_at_last
                                       && min_at_last;
            PER_LVL_MONTH: level_evt = sec_evt && sec_at_last
                                       && min_at_last && hour_at_last
                                       && day_at_last;
            default:       level_evt = 1'b0;
        endcase
    end

    always_comb
    begin
        next_cr1       = cr1;
        next_cr2       = cr2;
        next_adj_clear = 1'b0;
        if (wr_cr1)
        begin
            next_cr1 = reg_wdata; // [R4] [R5] [R6] [R10]
        end
        if (wr_cr2)
        begin
            next_cr2[B_THRESHOLD_SELECT]    = reg_wdata[B_THRESHOLD_SELECT];
            next_cr2[B_SPARE_STORAGE_ONE]   = reg_wdata[B_SPARE_STORAGE_ONE];
            next_cr2[B_CLOCK_OUT_DISABLE_A] =
                reg_wdata[B_CLOCK_OUT_DISABLE_A]; // [R18] [R19]
            // Flags take only a zero write
            if (!reg_wdata[B_LOW_VOLTAGE_FLAG])
            begin
                next_cr2[B_LOW_VOLTAGE_FLAG] = 1'b0; // [R20]
            end
            if (!reg_wdata[B_OSC_HALT_FLAG])
            begin
                next_cr2[B_OSC_HALT_FLAG] = 1'b0; // [R23]
            end
            if (!reg_wdata[B_PERIODIC_FLAG] && level_mode)
            begin
                next_cr2[B_PERIODIC_FLAG] = 1'b0; // [R25]
            end
            if (!reg_wdata[B_WEEKLY_ALARM_FLAG])
            begin
                next_cr2[B_WEEKLY_ALARM_FLAG] = 1'b0; // [R26]
            end
            if (!reg_wdata[B_DAILY_ALARM_FLAG])
            begin
                next_cr2[B_DAILY_ALARM_FLAG] = 1'b0; // [R26]
            end
        end
        // Hardware sets win over clears, except low voltage when its flag is already set
        if (sec_evt && vlow_s && !cr2[B_LOW_VOLTAGE_FLAG])
        begin
            next_cr2[B_LOW_VOLTAGE_FLAG] = 1'b1; // [R27] [R20]
        end
        if (level_mode)
        begin
            if (level_evt)
            begin
                next_cr2[B_PERIODIC_FLAG] = 1'b1; // [R25]
            end
        end
        else
        begin
            next_cr2[B_PERIODIC_FLAG] = per_low;
        end
        if (weekly_match && cr1[B_WEEKLY_ALARM_ENABLE])
        begin
            next_cr2[B_WEEKLY_ALARM_FLAG] = 1'b1; // [R26] [R5]
        end
        if (daily_match && cr1[B_DAILY_ALARM_ENABLE])
        begin
            next_cr2[B_DAILY_ALARM_FLAG] = 1'b1; // [R26] [R5]
        end
        if (!next_cr1[B_WEEKLY_ALARM_ENABLE])
        begin
            next_cr2[B_WEEKLY_ALARM_FLAG] = 1'b0; // [R5]
        end
        if (!next_cr1[B_DAILY_ALARM_ENABLE])
        begin
            next_cr2[B_DAILY_ALARM_FLAG] = 1'b0; // [R5]
        end
        if (halt_set)
        begin
            next_cr2[B_OSC_HALT_FLAG] = 1'b1; // [R21]
        end
        // Halt flag rising clears all controls
        if (halt_rise)
        begin
            next_cr1       = RST_ALARM_TIMER_CONTROL; // [R2] [R22]
            next_cr2       = 8'h00;
            next_cr2[B_OSC_HALT_FLAG] = 1'b1; // [R2] [R10]
            next_adj_clear = 1'b1; // [R2]
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cr1       <= RST_ALARM_TIMER_CONTROL; // [R4]
            cr2       <= RST_STATUS_FLAGS_CONTROL; // [R18]
            adj_clear <= 1'b0;
        end
        else
        begin
            cr1       <= next_cr1;
            cr2       <= next_cr2;
            adj_clear <= next_adj_clear;
        end
    end

    // ------------------------------------------------------------
    // Sub-second divider and second tick
    // ------------------------------------------------------------
    logic [DIV_W-1:0]   div;
    logic [DIV_W-1:0]   next_div;
    logic [DELAY_W-1:0] dly;
    logic [DELAY_W-1:0] next_dly;
    logic               next_sec_tick;
    logic               pulse_mode;

    assign sec_evt    = xtal_rise && div == DIV_LAST;
    assign pulse_mode = per_sel == PER_PULSE_2HZ
                        || per_sel == PER_PULSE_1HZ;

    always_comb
    begin
        next_div      = div;
        next_dly      = dly;
        next_sec_tick = 1'b0;
        if (xtal_rise)
        begin
            next_div = div + 15'h0001;
        end
        if (adj_event)
        begin
            if (adj_shorten)
            begin
                next_div = next_div + DIV_W'(adj_counts); // [R17]
            end
            else
            begin
                next_div = next_div - DIV_W'(adj_counts); // [R17]
            end
        end
        if (dly != '0)
        begin
            next_dly = dly - 10'h001;
            if (dly == 10'h001)
            begin
                next_sec_tick = 1'b1; // [R14]
            end
        end
        if (sec_evt)
        begin
            if (pulse_mode)
            begin
                next_dly = DELAY_W'(TICK_DELAY); // [R14]
            end
            else
            begin
                next_sec_tick = 1'b1; // [R16]
            end
        end
        if (sec_write)
        begin
            next_div = '0; // [R15]
            next_dly = '0;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            div      <= '0;
            dly      <= '0;
            sec_tick <= 1'b0;
            xtal_d   <= 1'b0;
        end
        else
        begin
            div      <= next_div;
            dly      <= next_dly;
            sec_tick <= next_sec_tick;
            xtal_d   <= xtal_s;
        end
    end

    // ------------------------------------------------------------
    // Pins and read data
    // ------------------------------------------------------------
    logic [7:0] next_rdata;
    logic [5:0] hour_enc;
    logic       next_int_n;
    logic       next_clk_out;

    rcs_hour_enc u_hour (
        .hour_bin  (hour_bin),
        .hour_24   (cr1[B_HOUR_MODE]),
        .hour_code (hour_enc)
    );

    always_comb
    begin
        unique case (per_sel) // [R12]
            PER_OFF:       per_low = 1'b0;
            PER_FIXED_LOW: per_low = 1'b1;
            PER_PULSE_2HZ: per_low = !div[DIV_W-2]; // [R15]
            PER_PULSE_1HZ: per_low = !div[DIV_W-1];
            default:       per_low = cr2[B_PERIODIC_FLAG]; // [R16]
        endcase
        next_int_n = !(per_low || cr2[B_WEEKLY_ALARM_FLAG]
                       || cr2[B_DAILY_ALARM_FLAG]); // [R22]
        next_clk_out = xtal_s;
        if (cr1[B_CLOCK_OUT_DISABLE_B] && cr2[B_CLOCK_OUT_DISABLE_A])
        begin
            next_clk_out = 1'b1; // [R9]
        end
        unique case (reg_addr)
            ADDR_ALARM_TIMER_CONTROL:  next_rdata = cr1;
            ADDR_STATUS_FLAGS_CONTROL: next_rdata = cr2;
            default:                   next_rdata = READ_UNMAPPED; // [R1]
        endcase
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            interrupt_out_n   <= 1'b1;
            crystal_clock_out <= 1'b1;
            reg_rdata         <= 8'h00;
            hour_code         <= 6'h00;
            hour_24_mode      <= 1'b0;
            test_mode         <= 1'b0;
            threshold_select  <= 1'b0;
        end
        else
        begin
            interrupt_out_n   <= next_int_n;
            crystal_clock_out <= next_clk_out;
            reg_rdata         <= next_rdata;
            hour_code         <= hour_enc; // [R7]
            hour_24_mode      <= cr1[B_HOUR_MODE]; // [R6]
            test_mode         <= cr1[B_TEST];
            threshold_select  <= cr2[B_THRESHOLD_SELECT]; // [R19]
        end
    end

endmodule

// *** rtl/rcs_pkg.sv ***
package rcs_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_ALARM_TIMER_CONTROL  = 4'hE;
    localparam logic [3:0] ADDR_STATUS_FLAGS_CONTROL = 4'hF;
    localparam logic [7:0] RST_ALARM_TIMER_CONTROL   = 8'h00;
    localparam logic [7:0] RST_STATUS_FLAGS_CONTROL  = 8'h10;
    localparam logic [7:0] READ_UNMAPPED             = 8'h00;

    // ------------------------------------------------------------
    // Field positions, alarm_timer_control
    // ------------------------------------------------------------
    localparam int unsigned B_WEEKLY_ALARM_ENABLE = 7;
    localparam int unsigned B_DAILY_ALARM_ENABLE  = 6;
    localparam int unsigned B_HOUR_MODE           = 5;
    localparam int unsigned B_CLOCK_OUT_DISABLE_B = 4;
    localparam int unsigned B_TEST                = 3;
    localparam int unsigned B_PERIODIC_SELECT_HI  = 2;
    localparam int unsigned B_PERIODIC_SELECT_LO  = 0;

    // ------------------------------------------------------------
    // Field positions, status_flags_control
    // ------------------------------------------------------------
    localparam int unsigned B_THRESHOLD_SELECT    = 7;
    localparam int unsigned B_LOW_VOLTAGE_FLAG    = 6;
    localparam int unsigned B_SPARE_STORAGE_ONE   = 5;
    localparam int unsigned B_OSC_HALT_FLAG       = 4;
    localparam int unsigned B_CLOCK_OUT_DISABLE_A = 3;
    localparam int unsigned B_PERIODIC_FLAG       = 2;
    localparam int unsigned B_WEEKLY_ALARM_FLAG   = 1;
    localparam int unsigned B_DAILY_ALARM_FLAG    = 0;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS   = 100;
    localparam int unsigned TICK_DELAY_NS   = 92000;
    localparam int unsigned TICK_DELAY_CYC  = TICK_DELAY_NS / CLK_PERIOD_NS;
    localparam int unsigned DIV_W           = 15;
    localparam logic [14:0] DIV_LAST        = 15'h7FFF;
    localparam int unsigned DELAY_W         = 10;
    localparam int unsigned ADJ_W           = 7;

    // ------------------------------------------------------------
    // Periodic interrupt selector codes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        PER_OFF       = 3'h0,
        PER_FIXED_LOW = 3'h1,
        PER_PULSE_2HZ = 3'h2,
        PER_PULSE_1HZ = 3'h3,
        PER_LVL_SEC   = 3'h4,
        PER_LVL_MIN   = 3'h5,
        PER_LVL_HOUR  = 3'h6,
        PER_LVL_MONTH = 3'h7
    } rcs_periodic_t;

endpackage

// *** rtl/rcs_sync.sv ***
`timescale 1ns/1ps

module rcs_sync #(
    parameter int unsigned WIDTH = 1
) (
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             arst_n,
    // Asynchronous inputs and their synchronised copies
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] next_stage1;
    logic [WIDTH-1:0] next_sync_out;

    always_comb
    begin
        next_stage1   = async_in;
        next_sync_out = stage1;
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            stage1   <= '0;
            sync_out <= '0;
        end
        else
        begin
            stage1   <= next_stage1;
            sync_out <= next_sync_out;
        end
    end

endmodule

// *** rtl/rcs_hour_enc.sv ***
`timescale 1ns/1ps

module rcs_hour_enc (
    // Hour 0..23 in binary and counting mode
    input  wire logic [4:0] hour_bin,
    input  wire logic       hour_24,
    // Hour as the hour register shows it
    output logic      [5:0] hour_code
);

    logic [4:0] h12;
    logic [3:0] tens;
    logic [3:0] ones;

    always_comb
    begin
        h12  = hour_bin;
        tens = 4'h0;
        ones = 4'h0;
        if (!hour_24 && hour_bin >= 5'd12)
        begin
            h12 = hour_bin - 5'd12;
        end
        if (!hour_24 && h12 == 5'd0)
        begin
            h12 = 5'd12;
        end
        if (h12 >= 5'd20)
        begin
            tens = 4'h2;
            ones = 4'(h12 - 5'd20);
        end
        else if (h12 >= 5'd10)
        begin
            tens = 4'h1;
            ones = 4'(h12 - 5'd10);
        end
        else
        begin
            ones = h12[3:0];
        end
        hour_code = {tens[1:0], ones};
        // PM hours carry bit 5 in 12-hour mode
        if (!hour_24 && hour_bin >= 5'd12)
        begin
            hour_code = hour_code | 6'h20; // [R7]
        end
    end

endmodule

// *** test/rcs_ctrl_status_assertions.sv ***
`timescale 1ns/1ps

module rcs_ctrl_status_assertions
    import rcs_pkg::*;
(
    // Clock and reset
    input wire logic       ref_clk,
    input wire logic       arst_n,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic [7:0] reg_rdata,
    // Pins and status
    input wire logic       chip_enable,
    input wire logic [4:0] hour_bin,
    input wire logic       interrupt_out_n,
    input wire logic       adj_clear,
    input wire logic       hour_24_mode,
    input wire logic       test_mode,
    input wire logic       threshold_select,
    input wire logic [5:0] hour_code
);
    // ----------------
    // Port checks
    // ----------------
    default clocking dc @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);

    AST_WR_E: assert property (
        (reg_wr && reg_addr == ADDR_ALARM_TIMER_CONTROL) ##1
        (reg_addr == ADDR_ALARM_TIMER_CONTROL) |=>
        reg_rdata == $past(reg_wdata, 2))
        else $error("Control one readback wrong");
    AST_UNMAPPED: assert property (
        reg_addr < ADDR_ALARM_TIMER_CONTROL |=> reg_rdata == READ_UNMAPPED)
        else $error("Unmapped address nonzero");
    AST_CTRL_COPY: assert property (
        (reg_addr == ADDR_ALARM_TIMER_CONTROL && !reg_wr && !adj_clear)[*3]
        |-> hour_24_mode == reg_rdata[B_HOUR_MODE]
        && test_mode == reg_rdata[B_TEST])
        else $error("Control one copies wrong");
    AST_THR_COPY: assert property (
        (reg_addr == ADDR_STATUS_FLAGS_CONTROL && !reg_wr && !adj_clear)[*3]
        |-> threshold_select == reg_rdata[B_THRESHOLD_SELECT])
        else $error("Threshold copy wrong");
    AST_HOUR_PM12: assert property (
        (hour_bin == 5'h0C && !hour_24_mode)[*3] |-> hour_code == 6'h32)
        else $error("Noon code wrong");
    AST_HOUR_24: assert property (
        (hour_bin == 5'h0D && hour_24_mode)[*3] |-> hour_code == 6'h13)
        else $error("24-hour code wrong");
    AST_HALT_CLEAR: assert property (
        adj_clear |-> ##2 (interrupt_out_n && !hour_24_mode
        && !test_mode && !threshold_select))
        else $error("Controls not cleared");
    AST_HALT_READ: assert property (
        adj_clear && reg_addr == ADDR_STATUS_FLAGS_CONTROL |=>
        reg_rdata == RST_STATUS_FLAGS_CONTROL)
        else $error("Status wrong after halt");
    AST_CE_BLOCK: assert property (
        chip_enable[*5] |-> !adj_clear)
        else $error("Halt sensed while enabled");
    AST_FIXED_LOW: assert property (
        (reg_addr == ADDR_ALARM_TIMER_CONTROL && reg_rdata[2:0] == 3'h1)[*3]
        |-> !interrupt_out_n)
        else $error("Fixed low output high");

    COV_HALT: cover property (adj_clear);
    COV_INT: cover property ($fell(interrupt_out_n));
    COV_PM12: cover property (hour_code == 6'h32);
endmodule

bind rcs_ctrl_status rcs_ctrl_status_assertions u_chk (
    .ref_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rdata,
    .chip_enable, .hour_bin, .interrupt_out_n, .adj_clear, .hour_24_mode,
    .test_mode, .threshold_select, .hour_code
);

// *** test/rcs_host.sv ***
`timescale 1ns/1ps

module rcs_host
    import rcs_pkg::*;
(
    // Clock
    input  wire logic       ref_clk,
    // Register port towards the block
    output logic      [3:0] reg_addr,
    output logic      [7:0] reg_wdata,
    output logic            reg_wr,
    output logic            sec_write,
    input  wire logic [7:0] reg_rdata
);
    // ----------------
    // Host register accesses
    // ----------------
    initial
    begin
        reg_addr  = 4'h0;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        sec_write = 1'b0;
    end

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [7:0] v;
        v = d;
        if (a == 4'h7)
            v[7] = 1'b0;
        if (a == ADDR_ALARM_TIMER_CONTROL)
            v[B_TEST] = 1'b0;
        @(negedge ref_clk);
        reg_addr  = a;
        reg_wdata = v;
        reg_wr    = 1'b1;
        @(negedge ref_clk);
        reg_wr    = 1'b0;
        reg_wdata = ~v;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(negedge ref_clk);
        reg_addr = a;
        @(negedge ref_clk);
        d = reg_rdata;
    endtask

    task automatic sec;
        @(negedge ref_clk);
        sec_write = 1'b1;
        @(negedge ref_clk);
        sec_write = 1'b0;
    endtask
endmodule

// *** test/test_rtc_control_status_regs.sv ***
`timescale 1ns/1ps

module test_rtc_control_status_regs
    import rcs_pkg::*;
;
    localparam logic [3:0] AE = ADDR_ALARM_TIMER_CONTROL;
    localparam logic [3:0] AF = ADDR_STATUS_FLAGS_CONTROL;
    logic       ref_clk, arst_n, reg_wr, sec_write, xtal_clk, chip_enable;
    logic       osc_halt, vdd_low, weekly_match, daily_match, adj_event;
    logic       adj_shorten, interrupt_out_n, crystal_clock_out;
    logic       adj_clear, hour_24_mode, test_mode, threshold_select;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    logic [4:0] hour_bin;
    logic [6:0] adj_counts;
    logic [5:0] hour_code;
    int         n_errors, num_checks, cycles;

    rcs_ctrl_status #(.TICK_DELAY(4)) dut (
        .ref_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .sec_write,
        .reg_rdata, .xtal_clk, .chip_enable, .osc_halt, .vdd_low,
        .sec_at_last(1'b0), .min_at_last(1'b0), .hour_at_last(1'b0),
        .day_at_last(1'b0), .hour_bin, .weekly_match, .daily_match,
        .adj_event, .adj_shorten, .adj_counts, .interrupt_out_n,
        .crystal_clock_out, .sec_tick(), .adj_clear, .hour_24_mode,
        .test_mode, .threshold_select, .hour_code
    );

    rcs_host host (
        .ref_clk, .reg_addr, .reg_wdata, .reg_wr, .sec_write, .reg_rdata
    );

    // ----------------
    // Clocks, timeout and helpers
    // ----------------
    initial
    begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    initial
    begin
        xtal_clk = 1'b0;
        #137;
        forever #400 xtal_clk = ~xtal_clk;
    end

    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_errors++;
            test_done;
        end
    end

    task automatic test_done;
        $display("Checks %0d, mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wt(input int k);
        repeat (k) @(negedge ref_clk);
    endtask

    task automatic chk_reg(input logic [3:0] a, input logic [7:0] exp);
        logic [7:0] d;
        host.rd(a, d);
        chk(d, exp);
    endtask

    task automatic cnt_low(output logic [7:0] n);
        n = 8'h00;
        repeat (40)
        begin
            @(negedge ref_clk);
            if (crystal_clock_out !== 1'b1)
                n++;
        end
    endtask

    task automatic hit(input logic wk);
        @(negedge ref_clk);
        weekly_match = wk;
        daily_match  = ~wk;
        @(negedge ref_clk);
        weekly_match = 1'b0;
        daily_match  = 1'b0;
    endtask

    // ----------------
    // Scenarios
    // ----------------
    task automatic t_regs;
        chk_reg(AE, RST_ALARM_TIMER_CONTROL);
        chk_reg(AF, RST_STATUS_FLAGS_CONTROL);
        host.wr(4'h3, 8'hFF);
        chk_reg(4'h3, READ_UNMAPPED);
        host.wr(AF, 8'h00);
        chk_reg(AF, 8'h00);
        vdd_low   = 1'b1;
        adj_event = 1'b1;
        host.wr(AF, 8'hFF);
        vdd_low   = 1'b0;
        adj_event = 1'b0;
        chk_reg(AF, 8'hA8);
        chk({7'h00, threshold_select}, 8'h01);
        host.wr(AE, 8'hEC);
        chk_reg(AE, 8'hE4);
        chk({6'h00, hour_24_mode, test_mode}, 8'h02);
        $display("Test registers done");
    endtask

    task automatic t_clkout;
        logic [7:0] n;
        host.wr(AE, 8'h10);
        host.wr(AF, 8'h08);
        wt(4);
        cnt_low(n);
        chk(n, 8'h00);
        host.wr(AE, 8'h00);
        wt(4);
        cnt_low(n);
        chk({7'h00, n > 8'h0A}, 8'h01);
        $display("Test clock output done");
    endtask

    task automatic t_hour;
        logic [4:0] hb [6];
        logic [5:0] hc [6];
        hb = '{5'h00, 5'h0C, 5'h0D, 5'h17, 5'h0D, 5'h00};
        hc = '{6'h12, 6'h32, 6'h21, 6'h31, 6'h13, 6'h00};
        for (int i = 0; i < 6; i++)
        begin
            if (i == 4)
                host.wr(AE, 8'h20);
            hour_bin = hb[i];
            wt(3);
            chk({2'h0, hour_code}, {2'h0, hc[i]});
        end
        $display("Test hour code done");
    endtask

    task automatic t_alarm;
        host.wr(AE, 8'h80);
        hit(1'b1);
        wt(3);
        chk({7'h00, interrupt_out_n}, 8'h00);
        chk_reg(AF, 8'h0A);
        host.wr(AF, 8'h08);
        chk_reg(AF, 8'h08);
        chk({7'h00, interrupt_out_n}, 8'h01);
        host.wr(AE, 8'h40);
        hit(1'b1);
        chk_reg(AF, 8'h08);
        hit(1'b0);
        chk_reg(AF, 8'h09);
        host.wr(AE, 8'h00);
        chk_reg(AF, 8'h08);
        $display("Test alarms done");
    endtask

    task automatic t_periodic;
        for (int c = 0; c < 8; c++)
        begin
            host.wr(AE, {5'h00, c[2:0]});
            if (c > 3)
                host.wr(AF, 8'h08);
            chk_reg(AE, {5'h00, c[2:0]});
            if (c < 2 || c > 3)
                chk({7'h00, interrupt_out_n}, {7'h00, c != 1});
        end
        host.wr(AE, 8'h03);
        host.sec;
        wt(3);
        chk({7'h00, interrupt_out_n}, 8'h00);
        $display("Test periodic done");
    endtask

    task automatic t_halt;
        logic [7:0] n;
        chip_enable = 1'b1;
        host.wr(AE, 8'h24);
        host.wr(AF, 8'hA8);
        osc_halt = 1'b1;
        wt(8);
        chk_reg(AF, 8'hA8);
        chip_enable = 1'b0;
        for (int i = 0; i < 12 && adj_clear !== 1'b1; i++)
            @(negedge ref_clk);
        chk({7'h00, adj_clear}, 8'h01);
        wt(3);
        chk({5'h00, hour_24_mode, test_mode, threshold_select}, 8'h00);
        chk({7'h00, interrupt_out_n}, 8'h01);
        chk_reg(AE, 8'h00);
        chk_reg(AF, 8'h10);
        cnt_low(n);
        chk({7'h00, n > 8'h0A}, 8'h01);
        host.wr(AF, 8'h00);
        chk_reg(AF, 8'h10);
        osc_halt = 1'b0;
        wt(4);
        host.wr(AF, 8'h00);
        chk_reg(AF, 8'h00);
        $display("Test halt done");
    endtask

    initial
    begin
        arst_n       = 1'b0;
        chip_enable  = 1'b0;
        osc_halt     = 1'b0;
        vdd_low      = 1'b0;
        hour_bin     = 5'h00;
        weekly_match = 1'b0;
        daily_match  = 1'b0;
        adj_event    = 1'b0;
        adj_shorten  = 1'b1;
        adj_counts   = 7'h10;
        repeat (6) @(posedge ref_clk);
        @(negedge ref_clk);
        arst_n = 1'b1;
        t_regs;
        t_clkout;
        t_hour;
        t_alarm;
        t_periodic;
        t_halt;
        test_done;
    end
endmodule
